// File: rtl/ledr_regs.sv
/*
  LED channel register bank: operation mode, direct pwm and output current
  registers for the red, green and blue channels, and the per-channel control
  handed to the sequencers, pwm generators and current sinks.
  Assumes an I2C slave engine on the same clock presents byte accesses on the
  register port, and that each sequencer supplies its own brightness value.
*/
module ledr_regs
(
  // clock and reset
  input  wire logic                          i_clock,
  input  wire logic                          i_rst_n,
  // register port from the serial engine
  input  wire logic                          i_reg_wr,
  input  wire logic [7:0]                    i_reg_addr,
  input  wire logic [7:0]                    i_reg_wdata,
  output logic      [7:0]                    o_reg_rdata,
  output logic                               o_mode_pending,
  // execution fields and sequencer brightness, index 0 red, 1 green, 2 blue
  input  wire logic [ledr_pkg::NUM_CHAN-1:0][1:0] i_execution_field,
  input  wire logic [ledr_pkg::NUM_CHAN-1:0][7:0] i_seq_brightness,
  // per-channel control
  output ledr_pkg::ledr_chan_t [ledr_pkg::NUM_CHAN-1:0] o_chan,
  output logic                               o_ctrl_tick
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ****************************************
  // controller tick divider
  // ****************************************
  localparam logic [10:0] TICK_LAST = 11'(ledr_pkg::CTRL_TICK_CYCLES - 1);

  logic [10:0] tick_cnt_d;
  logic [10:0] tick_cnt_q;
  logic        tick_d;
  logic        tick_q;

  always_comb
  begin
    tick_d     = (tick_cnt_q == TICK_LAST);
    tick_cnt_d = tick_d ? 11'h000 : tick_cnt_q + 11'h001;
  end

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      tick_cnt_q <= 11'h000;
      tick_q     <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // ****************************************
  // host-side registers
  // ****************************************
  logic [5:0]                          mode_host_d;
  logic [5:0]                          mode_host_q;
  logic [ledr_pkg::NUM_CHAN-1:0][7:0]  pwm_d;
  logic [ledr_pkg::NUM_CHAN-1:0][7:0]  pwm_q;
  logic [ledr_pkg::NUM_CHAN-1:0][7:0]  cur_d;
  logic [ledr_pkg::NUM_CHAN-1:0][7:0]  cur_q;
  logic [7:0]                          rdata_d;
  logic [7:0]                          rdata_q;

  always_comb
  begin
    mode_host_d = mode_host_q;
    pwm_d       = pwm_q;
    cur_d       = cur_q;
    if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        ledr_pkg::OFS_CHANNEL_OPERATION_MODE: mode_host_d = i_reg_wdata[5:0]; // [R11]
        ledr_pkg::OFS_RED_DIRECT_PWM:         pwm_d[0]    = i_reg_wdata;      // [R6]
        ledr_pkg::OFS_GREEN_DIRECT_PWM:       pwm_d[1]    = i_reg_wdata;      // [R7]
        ledr_pkg::OFS_BLUE_DIRECT_PWM:        pwm_d[2]    = i_reg_wdata;      // [R8]
        ledr_pkg::OFS_RED_OUTPUT_CURRENT:     cur_d[0]    = i_reg_wdata;      // [R9]
        ledr_pkg::OFS_GREEN_OUTPUT_CURRENT:   cur_d[1]    = i_reg_wdata;      // [R9]
        ledr_pkg::OFS_BLUE_OUTPUT_CURRENT:    cur_d[2]    = i_reg_wdata;      // [R9]
        default:                              mode_host_d = mode_host_q;
      endcase
    end
    // read data is registered: it reflects the address one cycle earlier
    unique case (i_reg_addr)
      ledr_pkg::OFS_CHANNEL_OPERATION_MODE: rdata_d = {2'h0, mode_host_q}; // [R11]
      ledr_pkg::OFS_RED_DIRECT_PWM:         rdata_d = pwm_q[0];
      ledr_pkg::OFS_GREEN_DIRECT_PWM:       rdata_d = pwm_q[1];
      ledr_pkg::OFS_BLUE_DIRECT_PWM:        rdata_d = pwm_q[2];
      ledr_pkg::OFS_RED_OUTPUT_CURRENT:     rdata_d = cur_q[0];
      ledr_pkg::OFS_GREEN_OUTPUT_CURRENT:   rdata_d = cur_q[1];
      ledr_pkg::OFS_BLUE_OUTPUT_CURRENT:    rdata_d = cur_q[2];
      default:                              rdata_d = ledr_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mode_host_q <= ledr_pkg::MODE_RESET;
      pwm_q       <= {ledr_pkg::NUM_CHAN{ledr_pkg::DIRECT_PWM_RESET}};
      cur_q       <= {ledr_pkg::NUM_CHAN{ledr_pkg::OUTPUT_CURRENT_RESET}};
      rdata_q     <= ledr_pkg::UNMAPPED_READ;
    end
    else
    begin
      mode_host_q <= mode_host_d;
      pwm_q       <= pwm_d;
      cur_q       <= cur_d;
      rdata_q     <= rdata_d;
    end
  end

  // ****************************************
  // mode transfer to the controller tick
  // ****************************************
  // a write landing in the same cycle as the tick stays pending for the next
  // tick, so no update is lost; a second write before that tick overwrites
  // the first, which is why the host must space its writes
  logic [5:0] mode_app_d;
  logic [5:0] mode_app_q;
  logic       pend_d;
  logic       pend_q;

  always_comb
  begin
    mode_app_d = mode_app_q;
    pend_d     = pend_q;
    if (tick_q && pend_q)
    begin
      mode_app_d = mode_host_q;                          // [R4]
      pend_d     = 1'b0;
    end
    if (i_reg_wr && (i_reg_addr == ledr_pkg::OFS_CHANNEL_OPERATION_MODE))
    begin
      pend_d = 1'b1;                                     // [R4]
    end
  end

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mode_app_q <= ledr_pkg::MODE_RESET;
      pend_q     <= 1'b0;
    end
    else
    begin
      mode_app_q <= mode_app_d;
      pend_q     <= pend_d;
    end
  end

  // ****************************************
  // per-channel control
  // ****************************************
  localparam int MODE_LSB [ledr_pkg::NUM_CHAN] = '{ledr_pkg::RED_MODE_LSB,
                                                  ledr_pkg::GREEN_MODE_LSB,
                                                  ledr_pkg::BLUE_MODE_LSB};

  // each channel builds its next value in a local variable; the net only gathers
  // them, so no variable is written from more than one process
  wire  ledr_pkg::ledr_chan_t [ledr_pkg::NUM_CHAN-1:0] chan_d;
  ledr_pkg::ledr_chan_t [ledr_pkg::NUM_CHAN-1:0]       chan_q;

  for (genvar c = 0; c < ledr_pkg::NUM_CHAN; c++)
  begin : g_chan
    ledr_pkg::ledr_mode_t mode;
    ledr_pkg::ledr_chan_t nxt_d;

    assign mode = ledr_pkg::ledr_mode_t'(mode_app_q[MODE_LSB[c] +: 2]); // [R1] [R2] [R3]

    always_comb
    begin
      nxt_d.mode       = mode;
      nxt_d.current    = cur_q[c];                        // [R9]
      // pulse once when the load mode is taken up on a tick
      nxt_d.pc_clear   = (mode == ledr_pkg::MODE_LOAD) &&
                         (chan_q[c].mode != ledr_pkg::MODE_LOAD); // [R1] [R2] [R3]
      nxt_d.exec       = ledr_pkg::EXEC_HOLD;
      nxt_d.brightness = 8'h00;
      unique case (mode)
        ledr_pkg::MODE_RUN:
        begin
          nxt_d.exec       = ledr_pkg::ledr_exec_t'(i_execution_field[c]); // [R10]
          nxt_d.brightness = i_seq_brightness[c];
        end
        ledr_pkg::MODE_DIRECT:
        begin
          nxt_d.brightness = pwm_q[c];                   // [R6] [R7] [R8]
        end
        ledr_pkg::MODE_DISABLED,
        ledr_pkg::MODE_LOAD:
        begin
          nxt_d.brightness = 8'h00;
        end
      endcase
    end

    assign chan_d[c] = nxt_d;
  end

  always_ff @(posedge i_clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      for (int c = 0; c < ledr_pkg::NUM_CHAN; c++)
      begin
        chan_q[c].mode       <= ledr_pkg::MODE_DISABLED;
        chan_q[c].exec       <= ledr_pkg::EXEC_HOLD;
        chan_q[c].pc_clear   <= 1'b0;
        chan_q[c].brightness <= 8'h00;
        chan_q[c].current    <= ledr_pkg::OUTPUT_CURRENT_RESET;
      end
    end
    else
    begin
      chan_q <= chan_d;
    end
  end

  assign o_chan         = chan_q;
  assign o_reg_rdata    = rdata_q;
  assign o_mode_pending = pend_q;
  assign o_ctrl_tick    = tick_q;

endmodule

// File: rtl/ledr_pkg.sv
/*
  Package for the LED channel register bank: register offsets, field
  positions, reset values, mode and execution codes, the controller tick
  divider and the per-channel carrier struct.
  Assumes a 40 MHz system clock. The controller tick is derived from that
  clock rather than taken from a separate 32 kHz clock domain.
*/
// What this block does
// [R1] red mode bits 5:4: 00 off, 01 load, clear pc, 10 run, 11 direct
// [R2] green mode is bits 3:2, same codes, acting on green and its pc
// [R3] blue mode is bits 1:0, same codes, acting on blue and its pc
// [R4] mode writes take effect only on the next 32 kHz controller tick
// [R5] host spaces mode register writes by more than 153 us
// [R6] red brightness follows pwm register 02h in direct mode, reset zero
// [R7] green direct pwm lives in register 03h and drives green in direct mode
// [R8] blue direct pwm lives in register 04h and drives blue in direct mode
// [R9] eight-bit current code per channel, 0.1 mA per step, resets to afh
// [R10] in run mode the sequencer obeys the channel execution field
// [R11] mode register bits 7:6 ignore writes and read as zero
package ledr_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_CHANNEL_OPERATION_MODE = 8'h01;
  localparam logic [7:0] OFS_RED_DIRECT_PWM         = 8'h02;
  localparam logic [7:0] OFS_GREEN_DIRECT_PWM       = 8'h03;
  localparam logic [7:0] OFS_BLUE_DIRECT_PWM        = 8'h04;
  localparam logic [7:0] OFS_RED_OUTPUT_CURRENT     = 8'h05;
  localparam logic [7:0] OFS_GREEN_OUTPUT_CURRENT   = 8'h06;
  localparam logic [7:0] OFS_BLUE_OUTPUT_CURRENT    = 8'h07;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int         NUM_CHAN            = 3;
  localparam int         RED_MODE_LSB        = 4;
  localparam int         GREEN_MODE_LSB      = 2;
  localparam int         BLUE_MODE_LSB       = 0;
  localparam logic [5:0] MODE_RESET          = 6'h00;
  localparam logic [7:0] DIRECT_PWM_RESET    = 8'h00;
  localparam logic [7:0] OUTPUT_CURRENT_RESET = 8'haf;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

  // ****************************************
  // timing
  // ****************************************
  localparam longint SYS_CLK_HZ        = 40000000;
  localparam longint CTRL_CLK_HZ       = 32768;
  localparam int     CTRL_TICK_CYCLES  = int'(SYS_CLK_HZ / CTRL_CLK_HZ);
  localparam int     MODE_WRITE_GAP_US = 153;
  localparam int     MODE_WRITE_GAP_CYCLES = int'((MODE_WRITE_GAP_US * SYS_CLK_HZ + 999999) / 1000000);

  // ****************************************
  // codes
  // ****************************************
  typedef enum logic [1:0]
  {
    MODE_DISABLED = 2'h0,
    MODE_LOAD     = 2'h1,
    MODE_RUN      = 2'h2,
    MODE_DIRECT   = 2'h3
  } ledr_mode_t;

  typedef enum logic [1:0]
  {
    EXEC_HOLD    = 2'h0,
    EXEC_STEP    = 2'h1,
    EXEC_FREE    = 2'h2,
    EXEC_ONCE    = 2'h3
  } ledr_exec_t;

  // per-channel outputs towards sequencer, pwm stage and current sink
  typedef struct packed
  {
    ledr_mode_t  mode;
    ledr_exec_t  exec;
    logic        pc_clear;
    logic [7:0]  brightness;
    logic [7:0]  current;
  } ledr_chan_t;

endpackage

// File: verif/ledr_regs_props.sv
/*
  checker for the led channel register bank.
  assumes it sees only the ports of ledr_regs on one 40 MHz clock.
*/
module ledr_regs_props
(
  // clock and reset
  input wire logic                                  i_clock,
  input wire logic                                  i_rst_n,
  // register port
  input wire logic                                  i_reg_wr,
  input wire logic [7:0]                            i_reg_addr,
  input wire logic [7:0]                            i_reg_wdata,
  input wire logic [7:0]                            o_reg_rdata,
  input wire logic                                  o_mode_pending,
  // channel side
  input wire logic [ledr_pkg::NUM_CHAN-1:0][1:0]    i_execution_field,
  input wire logic [ledr_pkg::NUM_CHAN-1:0][7:0]    i_seq_brightness,
  input wire ledr_pkg::ledr_chan_t [ledr_pkg::NUM_CHAN-1:0] o_chan,
  input wire logic                                  o_ctrl_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  // ********************
  // tick spacing helper
  // ********************
  logic [10:0] cnt_q;
  logic        got_q;
  // first tick is skipped: the divider starts after the internal reset copy
  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
    begin
      cnt_q <= 11'h000;
      got_q <= 1'b0;
    end
    else
    begin
      cnt_q <= o_ctrl_tick ? 11'h000 : cnt_q + 11'h001;
      got_q <= got_q | o_ctrl_tick;
    end
  a_tick_period: assert property (got_q |-> o_ctrl_tick == (cnt_q == 11'(ledr_pkg::CTRL_TICK_CYCLES - 1)))
    else $error("controller tick period wrong");
  a_pend_set: assert property (i_reg_wr && i_reg_addr == 8'h01 |=> o_mode_pending)
    else $error("mode write not pending");
  a_pend_clear: assert property (o_ctrl_tick && !(i_reg_wr && i_reg_addr == 8'h01) |=> !o_mode_pending)
    else $error("pending not cleared by tick");
  a_rd_top: assert property ($past(i_reg_addr) == 8'h01 |-> o_reg_rdata[7:6] == 2'h0)
    else $error("mode bits 7:6 not zero");
  a_rd_unmapped: assert property (!($past(i_reg_addr) inside {[8'h01:8'h07]}) |-> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  for (genvar k = 0; k < 3; k++)
  begin : g_chan
    a_cur_write: assert property (i_reg_wr && i_reg_addr == 8'(5 + k)
      |-> ##2 o_chan[k].current == $past(i_reg_wdata, 2))
      else $error("current code not applied");
    a_mode_tick: assert property ($changed(o_chan[k].mode) |-> $past(o_ctrl_tick, 2))
      else $error("mode changed off tick");
    a_pc_load: assert property (o_chan[k].pc_clear ==
      (o_chan[k].mode == ledr_pkg::MODE_LOAD && $past(o_chan[k].mode) != ledr_pkg::MODE_LOAD))
      else $error("pc clear pulse wrong");
    a_bright_off: assert property (!o_chan[k].mode[1] |-> o_chan[k].brightness == 8'h00)
      else $error("brightness not zero");
    a_exec_hold: assert property (o_chan[k].mode != ledr_pkg::MODE_RUN |-> o_chan[k].exec == ledr_pkg::EXEC_HOLD)
      else $error("exec not hold");
    a_exec_run: assert property ($past(o_chan[k].mode) == ledr_pkg::MODE_RUN
      && o_chan[k].mode == ledr_pkg::MODE_RUN |-> o_chan[k].exec == $past(i_execution_field[k])
      && o_chan[k].brightness == $past(i_seq_brightness[k]))
      else $error("run outputs wrong");
  end
  c_tick_pend: cover property (o_ctrl_tick && o_mode_pending);
  c_pc: cover property (o_chan[0].pc_clear);
  c_run: cover property (o_chan[1].mode == ledr_pkg::MODE_RUN);
endmodule

bind ledr_regs ledr_regs_props i_ledr_regs_props
(
  .i_clock           (i_clock),
  .i_rst_n           (i_rst_n),
  .i_reg_wr          (i_reg_wr),
  .i_reg_addr        (i_reg_addr),
  .i_reg_wdata       (i_reg_wdata),
  .o_reg_rdata       (o_reg_rdata),
  .o_mode_pending    (o_mode_pending),
  .i_execution_field (i_execution_field),
  .i_seq_brightness  (i_seq_brightness),
  .o_chan            (o_chan),
  .o_ctrl_tick       (o_ctrl_tick)
);

// File: verif/ledr_host.sv
/*
  host model: byte register master standing in for the serial host.
  assumes the bank samples its port on the rising clock edge.
*/
module ledr_host
(
  // register port
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr    = 1'b0,
  output logic [7:0]      o_addr  = 8'h00,
  output logic [7:0]      o_wdata = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap_q = 7000;
  always @(posedge i_clock)
    gap_q <= (o_wr && o_addr == 8'h01) ? 0 : gap_q + 1;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h01)
      while (gap_q <= ledr_pkg::MODE_WRITE_GAP_CYCLES)
        @(posedge i_clock);
    @(posedge i_clock);
    #2;
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_clock);
    #2;
    o_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    #2;
    o_addr = a;
    @(posedge i_clock);
    #1;
    d = i_rdata;
  endtask
endmodule

// File: verif/ledr_regs_bench.sv
/*
  bench for the led register bank: register traffic through the host model.
  assumes ledr_regs, ledr_host and the bound checker.
*/
module ledr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clock = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      wr;
  logic [7:0]                addr;
  logic [7:0]                wdata;
  logic [7:0]                rdata;
  logic                      pend;
  logic                      tick;
  logic [2:0][1:0]           exec = 6'h2a;
  logic [2:0][7:0]           seqb = 24'h332211;
  ledr_pkg::ledr_chan_t [2:0] chan;
  logic [7:0]                pwm [3] = '{8'h5a, 8'ha5, 8'h3c};
  logic [5:0]                mtab [6] = '{6'h1b, 6'h2d, 6'h36, 6'h00, 6'h3f, 6'h2a};
  logic [5:0]                prev = 6'h00;
  int                        n_errors = 0;
  int                        checks_done = 0;
  always #12.5 clock = ~clock;
  ledr_regs i_ledr_regs (.i_clock(clock), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_mode_pending(pend), .i_execution_field(exec),
    .i_seq_brightness(seqb), .o_chan(chan), .o_ctrl_tick(tick));
  ledr_host i_ledr_host (.i_clock(clock), .i_rdata(rdata), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));
  // ********************
  // checking helpers
  // ********************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_ledr_host.rd(a, d);
    chk(d, exp);
  endtask
  // bits 7:6 written high on purpose, they must not stick
  task automatic setmode(input logic [5:0] m);
    int n;
    logic [1:0] f;
    logic [1:0] pf;
    i_ledr_host.wr(8'h01, {2'h3, m});
    chk(8'(pend), 8'h01);
    chk(8'(chan[0].mode), 8'(prev[5:4]));
    for (n = 0; n < 1300 && tick !== 1'b1; n++)
      @(posedge clock) #1;
    if (n == 1300)
    begin
      n_errors++;
      print_verdict();
    end
    repeat (2) @(posedge clock);
    #1;
    chk(8'(pend), 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      f = m[4 - 2 * k +: 2];
      pf = prev[4 - 2 * k +: 2];
      chk(8'(chan[k].mode), 8'(f));
      chk(8'(chan[k].pc_clear), 8'(f == 2'h1 && pf != 2'h1));
      chk(8'(chan[k].exec), f == 2'h2 ? 8'(exec[k]) : 8'h00);
      chk(chan[k].brightness, f == 2'h3 ? pwm[k] : f == 2'h2 ? seqb[k] : 8'h00);
    end
    prev = m;
    rdchk(8'h01, {2'h0, m});
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    #2;
    rst_n = 1'b1;
    repeat (3) @(posedge clock);
    for (int a = 0; a < 9; a++)
      rdchk(8'(a), a > 4 && a < 8 ? 8'haf : 8'h00);
    i_ledr_host.wr(8'h00, 8'hff);
    i_ledr_host.wr(8'h08, 8'hff);
    rdchk(8'h00, 8'h00);
    rdchk(8'h08, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      i_ledr_host.wr(8'(5 + k), 8'(8'hff - k));
      i_ledr_host.wr(8'(2 + k), pwm[k]);
      rdchk(8'(2 + k), pwm[k]);
      rdchk(8'(5 + k), 8'(8'hff - k));
      chk(chan[k].current, 8'(8'hff - k));
    end
    for (int i = 0; i < 5; i++)
      setmode(mtab[i]);
    pwm[0] = 8'hc3;
    i_ledr_host.wr(8'h02, pwm[0]);
    repeat (2) @(posedge clock);
    #1;
    chk(chan[0].brightness, 8'hc3);
    setmode(mtab[5]);
    for (int e = 0; e < 4; e++)
    begin
      @(posedge clock);
      #2;
      exec = {3{2'(e)}};
      seqb = {3{8'(e * 8'h41)}};
      repeat (2) @(posedge clock);
      #1;
      chk(8'(chan[2].exec), 8'(e));
      chk(chan[0].brightness, 8'(e * 8'h41));
    end
    print_verdict();
  end
endmodule
